//--- fepc_bus_cycle.sv
`timescale 1ns/10ps
`default_nettype none
module fepc_bus_cycle
  import fepc_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          start,
  input  wire logic          wr,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic               done,
  output logic [DW-1:0]      rdata,
  output logic               flash_ce_n,
  output logic               flash_oe_n,
  output logic               flash_we_n,
  output logic [AW-1:0]      flash_addr,
  output logic [DW-1:0]      flash_dq_o,
  output logic               flash_dq_oe,
  input  wire logic [DW-1:0] flash_dq_i
);
  typedef enum logic [1:0] {E_IDLE, E_SET, E_STROBE, E_HOLD} fepc_cyc_t;

  fepc_cyc_t  st_r;
  logic [3:0] cnt_r;
  logic       wr_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r        <= E_IDLE;
      cnt_r       <= 4'h0;
      wr_r        <= 1'b0;
      done        <= 1'b0;
      rdata       <= 8'h00;
      flash_ce_n  <= 1'b1;
      flash_oe_n  <= 1'b1;
      flash_we_n  <= 1'b1;
      flash_addr  <= 19'h00000;
      flash_dq_o  <= 8'h00;
      flash_dq_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      case (st_r)
        E_IDLE: begin
          if (start) begin
            flash_addr <= addr;
            flash_dq_o <= wdata;
            wr_r       <= wr;
            flash_ce_n <= 1'b0;
            cnt_r      <= SETUP_CYC;
            st_r       <= E_SET;
          end
        end
        E_SET: begin
          // Address is stable before the strobe falls, data is held past its rise
          flash_dq_oe <= wr_r;
          if (cnt_r == 4'h0) begin
            flash_we_n <= ~wr_r;
            flash_oe_n <= wr_r;
            cnt_r      <= STROBE_CYC;
            st_r       <= E_STROBE;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        E_STROBE: begin
          if (cnt_r == 4'h0) begin
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            if (!wr_r) begin
              rdata <= flash_dq_i;
            end
            cnt_r <= HOLD_CYC;
            st_r  <= E_HOLD;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        default: begin
          if (cnt_r == 4'h0) begin
            flash_ce_n  <= 1'b1;
            flash_dq_oe <= 1'b0;
            done        <= 1'b1;
            st_r        <= E_IDLE;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- fepc_flash_host.sv
`timescale 1ns/10ps
`default_nettype none
module fepc_flash_host
  import fepc_pkg::*;
#(
  parameter int unsigned WIN_CYCLES    = WIN_CYC_DEF,
  parameter int unsigned RESUME_CYCLES = RESUME_GAP_CYC_DEF
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  output logic               flash_ce_n,
  output logic               flash_oe_n,
  output logic               flash_we_n,
  output logic [AW-1:0]      flash_addr,
  output logic [DW-1:0]      flash_dq_o,
  output logic               flash_dq_oe,
  input  wire logic [DW-1:0] flash_dq_i
);
  typedef enum logic [1:0] {S_IDLE, S_GO, S_WAIT, S_EVAL} fepc_state_t;

  fepc_state_t        state_r;
  fepc_op_t           op_r;
  logic [2:0]         step_r;
  logic               poll_r;
  logic               rd_n_r;
  logic               to_seen_r;
  logic [AW-1:0]      addr_r;
  logic [DW-1:0]      wdata_r;
  logic [DW-1:0]      rdata_r;
  logic [DW-1:0]      rd1_r;
  logic [DW-1:0]      rd2_r;
  logic               fail_r;
  logic               tmo_r;
  logic               refused_r;
  logic               id_mode_r;
  logic [TMR_W-1:0]   win_cnt_r;
  logic [TMR_W-1:0]   lock_cnt_r;
  logic [3:0]         wr_cnt_r;

  logic               cyc_start;
  logic               cyc_wr;
  logic               cyc_done;
  logic [AW-1:0]      cyc_addr;
  logic [DW-1:0]      cyc_data;
  logic [DW-1:0]      cyc_rdata;
  logic [2:0]         seq_len;
  logic               apb_wr;
  logic               ctrl_wr;
  logic               ctrl_ok;
  logic               win_open;
  logic               lock_on;
  logic               toggled;
  logic               last_wr;
  logic               fail_set;
  logic               tmo_set;
  logic               wr_end;
  fepc_op_t           req_op;

  // Window runs from a strobe's rise to the next strobe's fall, so the
  // counter leaves room for the hold, the start and the setup cycles
  localparam int unsigned WIN_SLACK = 32'(SETUP_CYC) + 32'(HOLD_CYC) + 32'd4;

  function automatic logic [AW+DW-1:0] seq_word(fepc_op_t op, logic [2:0] st,
                                                 logic [AW-1:0] a, logic [DW-1:0] d);
    logic [AW+DW-1:0] w;
    w = {a, d};
    case (op)
      OP_PROG: begin
        if (st == 3'h0) w = {UNLOCK1_ADDR, UNLOCK1_DATA};
        else if (st == 3'h1) w = {UNLOCK2_ADDR, UNLOCK2_DATA};
        else if (st == 3'h2) w = {UNLOCK1_ADDR, CMD_PROGRAM};
        else w = {a, d};
      end
      OP_ERASE: begin
        if (st == 3'h0 || st == 3'h3) w = {UNLOCK1_ADDR, UNLOCK1_DATA};
        else if (st == 3'h1 || st == 3'h4) w = {UNLOCK2_ADDR, UNLOCK2_DATA};
        else if (st == 3'h2) w = {UNLOCK1_ADDR, CMD_ERASE_SET};
        else w = {a, CMD_SECTOR};
      end
      OP_IDENT: begin
        if (st == 3'h0) w = {UNLOCK1_ADDR, UNLOCK1_DATA};
        else if (st == 3'h1) w = {UNLOCK2_ADDR, UNLOCK2_DATA};
        else w = {UNLOCK1_ADDR, CMD_IDENT};
      end
      OP_RESET:  w = {a, CMD_RESET};
      OP_SUSP:   w = {a, CMD_SUSPEND};
      OP_RESUME: w = {a, CMD_RESUME};
      OP_ADD:    w = {a, CMD_SECTOR};
      default:   w = {a, d};
    endcase
    return w;
  endfunction

  always_comb begin
    case (op_r)
      OP_PROG:  seq_len = LEN_PROG;
      OP_ERASE: seq_len = LEN_ERASE;
      OP_IDENT: seq_len = LEN_IDENT;
      default:  seq_len = LEN_SINGLE;
    endcase
  end

  assign cyc_start = (state_r == S_GO);
  assign cyc_wr    = !(poll_r || op_r == OP_READ || op_r == OP_POLL);
  assign {cyc_addr, cyc_data} = cyc_wr ? seq_word(op_r, step_r, addr_r, wdata_r)
                                       : {addr_r, wdata_r};
  assign win_open  = (win_cnt_r != '0);
  assign lock_on   = (lock_cnt_r != '0);
  assign toggled   = rd1_r[ACTIVITY_TOGGLE_BIT] ^ rd2_r[ACTIVITY_TOGGLE_BIT];
  assign last_wr   = (step_r == seq_len - 3'h1);
  assign wr_end    = (state_r == S_WAIT) && cyc_done && cyc_wr && last_wr;

  fepc_bus_cycle u_cyc (
    .pclk        (pclk),
    .presetn     (presetn),
    .start       (cyc_start),
    .wr          (cyc_wr),
    .addr        (cyc_addr),
    .wdata       (cyc_data),
    .done        (cyc_done),
    .rdata       (cyc_rdata),
    .flash_ce_n  (flash_ce_n),
    .flash_oe_n  (flash_oe_n),
    .flash_we_n  (flash_we_n),
    .flash_addr  (flash_addr),
    .flash_dq_o  (flash_dq_o),
    .flash_dq_oe (flash_dq_oe),
    .flash_dq_i  (flash_dq_i)
  );

  // Register bus: zero wait states, error on unmapped offsets
  assign pready  = 1'b1;
  assign apb_wr  = psel && penable && pwrite;
  assign ctrl_wr = apb_wr && (paddr == REG_CTRL);
  assign req_op  = fepc_op_t'(pwdata[3:0]);

  always_comb begin
    ctrl_ok = (state_r == S_IDLE) && (pwdata[3:0] <= 4'(OP_POLL));
    if (id_mode_r && req_op != OP_READ && req_op != OP_RESET) ctrl_ok = 1'b0;
    if (req_op == OP_ADD && !win_open) ctrl_ok = 1'b0;
    if (req_op == OP_SUSP && lock_on) ctrl_ok = 1'b0;
  end

  always_comb begin
    pslverr = 1'b0;
    prdata  = 32'h00000000;
    if (paddr == REG_CTRL) begin
      prdata = {28'h0000000, 4'(op_r)};
    end else if (paddr == REG_ADDR) begin
      prdata = {13'h0000, addr_r};
    end else if (paddr == REG_WDATA) begin
      prdata = {24'h000000, wdata_r};
    end else if (paddr == REG_STATUS) begin
      prdata = {25'h0000000, id_mode_r, lock_on, win_open, refused_r, tmo_r, fail_r,
                state_r != S_IDLE};
    end else if (paddr == REG_RDATA) begin
      prdata = {24'h000000, rdata_r};
    end else begin
      pslverr = psel && penable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_r  <= 19'h00000;
      wdata_r <= 8'h00;
    end else if (apb_wr && paddr == REG_ADDR && state_r == S_IDLE) begin
      addr_r <= pwdata[AW-1:0];
    end else if (apb_wr && paddr == REG_WDATA && state_r == S_IDLE) begin
      wdata_r <= pwdata[DW-1:0];
    end
  end

  // Sticky flags: hardware set wins over a write-one clear in the same cycle
  assign fail_set = (state_r == S_EVAL) && toggled && rd2_r[TIMEOUT_FLAG_BIT] && to_seen_r;
  // Only a confirmed timeout counts: array data read after completion may carry bit 5
  assign tmo_set  = (state_r == S_EVAL) && toggled && rd2_r[TIMEOUT_FLAG_BIT] && to_seen_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_r    <= 1'b0;
      tmo_r     <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      if (apb_wr && paddr == REG_STATUS) begin
        if (pwdata[ST_FAIL]) fail_r <= 1'b0;
        if (pwdata[ST_TMO]) tmo_r <= 1'b0;
        if (pwdata[ST_REFUSED]) refused_r <= 1'b0;
      end
      if (ctrl_wr && !ctrl_ok) refused_r <= 1'b1;
      if (tmo_set) tmo_r <= 1'b1;
      // A failed program also shows when the top bits differ after completion
      if (fail_set || ((state_r == S_EVAL) && !toggled && op_r == OP_PROG &&
                       rd2_r[7:6] != wdata_r[7:6])) fail_r <= 1'b1;
    end
  end

  // Sector load window and post-resume suspend lockout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt_r <= '0;
    end else if (wr_end && (op_r == OP_ERASE || op_r == OP_ADD)) begin
      win_cnt_r <= TMR_W'(WIN_CYCLES - WIN_SLACK);
    end else if (wr_end && (op_r == OP_RESET || op_r == OP_SUSP)) begin
      win_cnt_r <= '0;
    end else if (win_open) begin
      win_cnt_r <= win_cnt_r - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cnt_r <= '0;
    end else if (wr_end && op_r == OP_RESUME) begin
      lock_cnt_r <= TMR_W'(RESUME_CYCLES);
    end else if (lock_on) begin
      lock_cnt_r <= lock_cnt_r - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      id_mode_r <= 1'b0;
    end else if (wr_end && op_r == OP_IDENT) begin
      id_mode_r <= 1'b1;
    end else if (wr_end && op_r == OP_RESET) begin
      id_mode_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_cnt_r <= 4'h0;
    end else if (ctrl_wr && ctrl_ok) begin
      wr_cnt_r <= 4'h0;
    end else if ((state_r == S_WAIT) && cyc_done && cyc_wr) begin
      wr_cnt_r <= wr_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r   <= S_IDLE;
      op_r      <= OP_READ;
      step_r    <= 3'h0;
      poll_r    <= 1'b0;
      rd_n_r    <= 1'b0;
      to_seen_r <= 1'b0;
      rdata_r   <= 8'h00;
      rd1_r     <= 8'h00;
      rd2_r     <= 8'h00;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (ctrl_wr && ctrl_ok) begin
            op_r      <= req_op;
            step_r    <= 3'h0;
            poll_r    <= 1'b0;
            rd_n_r    <= 1'b0;
            to_seen_r <= 1'b0;
            state_r   <= S_GO;
          end
        end
        S_GO: begin
          state_r <= S_WAIT;
        end
        S_WAIT: begin
          if (cyc_done) begin
            if (cyc_wr) begin
              if (!last_wr) begin
                step_r  <= step_r + 3'h1;
                state_r <= S_GO;
              end else if (op_r == OP_PROG) begin
                poll_r  <= 1'b1;
                rd_n_r  <= 1'b0;
                state_r <= S_GO;
              end else begin
                state_r <= S_IDLE;
              end
            end else if (op_r == OP_READ) begin
              rdata_r <= cyc_rdata;
              state_r <= S_IDLE;
            end else if (!rd_n_r) begin
              rd1_r   <= cyc_rdata;
              rd_n_r  <= 1'b1;
              state_r <= S_GO;
            end else begin
              rd2_r   <= cyc_rdata;
              rdata_r <= cyc_rdata;
              state_r <= S_EVAL;
            end
          end
        end
        default: begin
          rd_n_r <= 1'b0;
          if (!toggled) begin
            state_r <= S_IDLE;
          end else if (rd2_r[TIMEOUT_FLAG_BIT] && to_seen_r) begin
            op_r    <= OP_RESET;
            step_r  <= 3'h0;
            poll_r  <= 1'b0;
            state_r <= S_GO;
          end else begin
            // Toggle may stop just as the flag rises, so confirm once more
            if (rd2_r[TIMEOUT_FLAG_BIT]) to_seen_r <= 1'b1;
            state_r <= S_GO;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_unlock_first;
    cyc_start && cyc_wr && step_r == 3'h0 && op_r inside {OP_PROG, OP_ERASE, OP_IDENT}
      |=> !flash_ce_n && flash_addr == UNLOCK1_ADDR && flash_dq_o == UNLOCK1_DATA;
  endproperty
  a_unlock_first: assert property (p_unlock_first) else $error("bad first unlock");

  property p_erase_six;
    wr_end && op_r == OP_ERASE |-> wr_cnt_r == 4'h5 && cyc_data == CMD_SECTOR;
  endproperty
  a_erase_six: assert property (p_erase_six) else $error("erase not six writes");

  property p_prog_four;
    $rose(poll_r) && op_r == OP_PROG |-> wr_cnt_r == 4'h4 && flash_dq_o == wdata_r;
  endproperty
  a_prog_four: assert property (p_prog_four) else $error("program not four writes");

  property p_add_in_window;
    cyc_start && op_r == OP_ADD |-> $past(win_open);
  endproperty
  a_add_in_window: assert property (p_add_in_window) else $error("late sector");

  property p_suspend_gap;
    cyc_start && op_r == OP_SUSP |-> !$past(lock_on);
  endproperty
  a_suspend_gap: assert property (p_suspend_gap) else $error("suspend too soon");

  property p_timeout_reset;
    fail_set |=> cyc_start && cyc_data == CMD_RESET ##1 (state_r == S_WAIT)[*3];
  endproperty
  a_timeout_reset: assert property (p_timeout_reset) else $error("no reset on timeout");

  property p_id_locked;
    id_mode_r && ctrl_wr && !(req_op inside {OP_READ, OP_RESET}) |=> refused_r && state_r == S_IDLE;
  endproperty
  a_id_locked: assert property (p_id_locked) else $error("left id mode without reset");

  property p_win_len;
    wr_end && op_r == OP_ERASE |=> win_cnt_r == TMR_W'(WIN_CYCLES - WIN_SLACK);
  endproperty
  a_win_len: assert property (p_win_len) else $error("window length wrong");

  c_prog_done:  cover property (state_r == S_EVAL && !toggled && op_r == OP_PROG);
  c_auto_reset: cover property (fail_set);
  c_add_sector: cover property (wr_end && op_r == OP_ADD);
  c_refused:    cover property (ctrl_wr && !ctrl_ok);
endmodule
`default_nettype wire

//--- fepc_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
module fepc_flash_model
  import fepc_pkg::*;
#(
  parameter int WIN_NS = 500
) (
  input  wire logic          ce_n,
  input  wire logic          oe_n,
  input  wire logic          we_n,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] dq_w,
  output logic [DW-1:0]      dq_r
);
  logic [7:0]    mem [logic [AW-1:0]];
  logic [7:0]    pd;
  logic [7:0]    rv = 8'h00;
  logic [7:0]    er = 8'h00;
  logic [7:0]    sect = 8'h00;
  logic [AW-1:0] pa, al;
  logic          susp = 1'h0, tmo = 1'h0, fail_next = 1'h0, t6 = 1'h0, t2 = 1'h0;
  int            st = 0;
  int            seq = 0;
  int            left;
  realtime       tr;

  // Released or deselected lines show the inverse of the last byte
  assign dq_r = (ce_n === 1'h0 && oe_n === 1'h0) ? rv : ~rv;

  function automatic logic [7:0] arr(logic [AW-1:0] a);
    if (mem.exists(a)) return mem[a];
    return er[a[18:16]] ? 8'hff : a[7:0] ^ 8'h3c;
  endfunction

  task automatic upd();
    if (st == 2 && $realtime - tr > WIN_NS) begin
      st = 3;
      left = 4;
    end
  endtask

  task automatic cmd(logic [AW-1:0] a, logic [7:0] d);
    // Program data may equal the reset code, so the data cycle is taken first
    if (seq == 3) begin
      pa = a;
      pd = d;
      st = 1;
      left = 3;
      tmo = fail_next;
      fail_next = 1'h0;
      seq = 0;
    end else if (d == CMD_RESET) begin
      st = 0;
      seq = 0;
    end else if (st == 4) seq = 0;
    else if (seq == 0 && susp && d == CMD_RESUME) begin
      susp = 1'h0;
      st = 3;
      left = 4;
    end else if (seq == 2 && d == CMD_PROGRAM) seq = 3;
    else if (seq == 2 && d == CMD_ERASE_SET && !susp) seq = 4;
    else if (seq == 2 && d == CMD_IDENT) st = 4;
    else if (seq == 6 && d == CMD_SECTOR) begin
      st = 2;
      sect = 8'h01 << a[18:16];
      seq = 0;
    end else if ((seq == 0 || seq == 4) && a == UNLOCK1_ADDR && d == UNLOCK1_DATA) seq++;
    else if ((seq == 1 || seq == 5) && a == UNLOCK2_ADDR && d == UNLOCK2_DATA) seq++;
    else seq = 0;
  endtask

  always @(negedge we_n) al = addr;
  always @(posedge we_n) if (ce_n === 1'h0) begin
    upd();
    tr = $realtime;
    if (tmo && dq_w == CMD_RESET) begin
      st = 0;
      tmo = 1'h0;
    end else if (st == 2 && dq_w == CMD_SECTOR) sect[al[18:16]] = 1'h1;
    else if (st >= 2 && st <= 3 && dq_w == CMD_SUSPEND) begin
      st = 0;
      susp = 1'h1;
    end else if (st == 2) begin
      st = 0;
      sect = 8'h00;
    end else if (st != 1 && st != 3) cmd(al, dq_w);
  end

  always @(negedge oe_n) if (ce_n === 1'h0) begin
    upd();
    if (st == 1) begin
      t6 = ~t6;
      rv = {~pd[7], t6, tmo, 5'h00};
      left = left - {31'h0, !tmo};
      if (left == 0) begin
        mem[pa] = arr(pa) & pd;
        st = 0;
      end
    end else if (st == 2 || st == 3) begin
      t6 = ~t6;
      t2 = t2 ^ sect[addr[18:16]];
      rv = {1'h0, t6, 1'h0, st == 3, 1'h0, t2, 2'h0};
      left = left - (st == 3);
      if (st == 3 && left == 0) begin
        er = er | sect;
        foreach (mem[k]) if (sect[k[18:16]]) mem[k] = 8'hff;
        st = 0;
        sect = 8'h00;
      end
    end else if (susp && sect[addr[18:16]]) begin
      t2 = ~t2;
      rv = {1'h1, t6, 1'h0, 2'h0, t2, 2'h0};
    end else rv = arr(addr);
  end
endmodule
`default_nettype wire

//--- fepc_pkg.sv
`default_nettype none
package fepc_pkg;
  // Clock and timing
  localparam int unsigned CLK_NS             = 10;
  localparam int unsigned WIN_US             = 50;
  localparam int unsigned WIN_CYC_DEF        = (WIN_US * 1000) / CLK_NS;
  localparam int unsigned RESUME_GAP_US      = 400;
  localparam int unsigned RESUME_GAP_CYC_DEF = (RESUME_GAP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TMR_W              = 16;

  // Pin cycle phases, in clock cycles minus one
  localparam logic [3:0]  SETUP_CYC  = 4'h1;
  localparam logic [3:0]  STROBE_CYC = 4'h4;
  localparam logic [3:0]  HOLD_CYC   = 4'h1;

  localparam int unsigned AW = 19;
  localparam int unsigned DW = 8;

  // Register offsets
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_ADDR   = 12'h004;
  localparam logic [11:0] REG_WDATA  = 12'h008;
  localparam logic [11:0] REG_STATUS = 12'h00c;
  localparam logic [11:0] REG_RDATA  = 12'h010;

  // Status register bit positions
  localparam int unsigned ST_BUSY    = 0;
  localparam int unsigned ST_FAIL    = 1;
  localparam int unsigned ST_TMO     = 2;
  localparam int unsigned ST_REFUSED = 3;
  localparam int unsigned ST_WIN     = 4;
  localparam int unsigned ST_LOCK    = 5;
  localparam int unsigned ST_IDM     = 6;

  // Status byte fields read back from the device
  localparam int unsigned COMPLETION_POLL_BIT  = 7;
  localparam int unsigned ACTIVITY_TOGGLE_BIT  = 6;
  localparam int unsigned TIMEOUT_FLAG_BIT     = 5;
  localparam int unsigned ERASE_WINDOW_BIT     = 3;
  localparam int unsigned SECTOR_TOGGLE_BIT    = 2;

  // Command table
  localparam logic [18:0] UNLOCK1_ADDR  = 19'h00555;
  localparam logic [7:0]  UNLOCK1_DATA  = 8'haa;
  localparam logic [18:0] UNLOCK2_ADDR  = 19'h002aa;
  localparam logic [7:0]  UNLOCK2_DATA  = 8'h55;
  localparam logic [7:0]  CMD_ERASE_SET = 8'h80;
  localparam logic [7:0]  CMD_SECTOR    = 8'h30;
  localparam logic [7:0]  CMD_SUSPEND   = 8'hb0;
  localparam logic [7:0]  CMD_RESUME    = 8'h30;
  localparam logic [7:0]  CMD_PROGRAM   = 8'ha0;
  localparam logic [7:0]  CMD_RESET     = 8'hf0;
  localparam logic [7:0]  CMD_IDENT     = 8'h90;
  localparam logic [2:0]  LEN_PROG      = 3'h4;
  localparam logic [2:0]  LEN_ERASE     = 3'h6;
  localparam logic [2:0]  LEN_IDENT     = 3'h3;
  localparam logic [2:0]  LEN_SINGLE    = 3'h1;

  typedef enum logic [3:0] {
    OP_READ, OP_RESET, OP_PROG, OP_ERASE, OP_ADD, OP_SUSP, OP_RESUME, OP_IDENT, OP_POLL
  } fepc_op_t;
endpackage
`default_nettype wire

//--- flash_erase_program_command_fsm_bench.sv
`timescale 1ns/10ps
`default_nettype none
module flash_erase_program_command_fsm_bench
  import fepc_pkg::*;
;
  typedef struct {string nm; logic [32:0] v; logic [32:0] m;} fepc_exp_t;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, ce_n, oe_n, we_n, dqoe;
  logic [18:0] fa, a;
  logic [7:0]  dqo, dqi, d, e8;
  int          num_errors = 0, checks_done = 0, cyc = 0;
  fepc_exp_t   eq[$];

  always #5 pclk = ~pclk;

  fepc_flash_host #(.WIN_CYCLES(50), .RESUME_CYCLES(100)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(fa),
    .flash_dq_o(dqo), .flash_dq_oe(dqoe), .flash_dq_i(dqi));
  fepc_flash_model dev_u (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(fa), .dq_w(dqo),
    .dq_r(dqi));

  task automatic close_out();
    if (num_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [32:0] seen, logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(logic w, logic [11:0] ad, logic [31:0] wd);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    r = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic ex(string nm, logic [11:0] ad, logic [32:0] v, logic [32:0] m);
    eq.push_back('{nm, v, m});
    apb(1'h0, ad, 32'h0);
  endtask

  task automatic op(logic [3:0] c, logic [18:0] ad, logic [7:0] wd);
    apb(1'h1, REG_ADDR, {13'h0, ad});
    apb(1'h1, REG_WDATA, {24'h0, wd});
    apb(1'h1, REG_CTRL, {28'h0, c});
    r = 32'h1;
    for (int i = 0; i < 3000 && r[ST_BUSY] !== 1'h0; i++) apb(1'h0, REG_STATUS, 32'h0);
    if (r[ST_BUSY] !== 1'h0) num_errors++;
  endtask

  task automatic rd(logic [18:0] ad, logic [7:0] v, logic [7:0] m);
    op(OP_READ, ad, 8'h00);
    ex("rdata", REG_RDATA, {25'h0, v}, {25'h0, m});
  endtask

  always @(posedge pclk) if (psel && penable && pready && !pwrite && eq.size() > 0) begin
    fepc_exp_t e;
    e = eq.pop_front();
    chk(e.nm, {pslverr, prdata} & e.m, e.v & e.m);
  end

  // Host drives data through the write strobe's rise and releases it for reads
  always @(posedge we_n) if (presetn && !ce_n) chk("dq drive", {32'h0, dqoe}, 33'h1);
  always @(negedge oe_n) if (presetn && !ce_n) chk("dq release", {32'h0, dqoe}, 33'h0);

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    void'($urandom(32'h10820c0b));
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    ex("status", REG_STATUS, 33'h0, 33'h7f);
    ex("unmapped", 12'h020, 33'h100000000, 33'h1ffffffff);
    rd(19'h00123, 8'h23 ^ 8'h3c, 8'hff);
    for (int i = 0; i < 4; i++) begin
      a = {3'h1, 4'(i), 12'($urandom)};
      d = 8'($urandom);
      e8 = (a[7:0] ^ 8'h3c) & d;
      op(OP_PROG, a, d);
      ex("prog", REG_STATUS, {31'h0, e8[7:6] != d[7:6], 1'h0}, 33'h7);
      apb(1'h1, REG_STATUS, 32'he);
      rd(a, e8, 8'hff);
    end
    op(OP_ERASE, 19'h20000, 8'h00);
    ex("window", REG_STATUS, 33'h10, 33'h10);
    op(OP_ADD, 19'h30000, 8'h00);
    op(OP_POLL, 19'h30000, 8'h00);
    rd(19'h21234, 8'hff, 8'hff);
    rd(19'h31234, 8'hff, 8'hff);
    op(OP_ADD, 19'h40000, 8'h00);
    ex("late add", REG_STATUS, 33'h8, 33'h1f);
    apb(1'h1, REG_STATUS, 32'he);
    op(OP_ERASE, 19'h40000, 8'h00);
    op(OP_RESET, 19'h40000, 8'h00);
    repeat (80) @(posedge pclk);
    rd(19'h40010, 8'h10 ^ 8'h3c, 8'hff);
    op(OP_ERASE, 19'h60000, 8'h00);
    op(OP_SUSP, 19'h60000, 8'h00);
    rd(19'h60100, 8'h80, 8'ha0);
    rd(19'h50020, 8'h20 ^ 8'h3c, 8'hff);
    op(OP_PROG, 19'h50021, 8'h00);
    rd(19'h50021, 8'h00, 8'hff);
    rd(19'h60100, 8'h80, 8'ha0);
    op(OP_RESUME, 19'h60000, 8'h00);
    op(OP_SUSP, 19'h60000, 8'h00);
    ex("lockout", REG_STATUS, 33'h28, 33'h28);
    apb(1'h1, REG_STATUS, 32'he);
    op(OP_POLL, 19'h60000, 8'h00);
    rd(19'h60100, 8'hff, 8'hff);
    op(OP_IDENT, 19'h00000, 8'h00);
    ex("ident", REG_STATUS, 33'h40, 33'h40);
    op(OP_PROG, 19'h00001, 8'h00);
    ex("ident prog", REG_STATUS, 33'h48, 33'h48);
    apb(1'h1, REG_STATUS, 32'he);
    op(OP_RESET, 19'h7ffff, 8'h00);
    rd(19'h00005, 8'h05 ^ 8'h3c, 8'hff);
    dev_u.fail_next = 1'h1;
    op(OP_PROG, 19'h10fff, 8'h00);
    ex("timeout", REG_STATUS, 33'h6, 33'h7);
    rd(19'h10fff, 8'hff ^ 8'h3c, 8'hff);
    close_out();
  end
endmodule
`default_nettype wire
